// [core/pbs_params.svh]
// register offsets, field positions and reset values of the power budget and status bank
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH
`define PBS_OFF_DSEL 12'h284
`define PBS_OFF_BDATA 12'h288
`define PBS_OFF_ALLOC 12'h28C
`define PBS_OFF_TABLE 12'h300
`define PBS_OFF_TABLE_LAST 12'h31C
`define PBS_OFF_STATUS 12'h400
`define PBS_OFF_CTRL 12'h404
`define PBS_OFF_LOCK 12'h408
`define PBS_ALLOC_SA_BIT 0
`define PBS_CTRL_REGUL_BIT 3
`define PBS_CTRL_BDVUL_BIT 4
`define PBS_STS_MODE_LSB 0
`define PBS_STS_CCDS_BIT 5
`define PBS_STS_CCUS_BIT 6
`define PBS_STS_LOCK_LSB 20
`define PBS_STS_MARK_LSB 28
`define PBS_NUM_WORDS 8
`define PBS_DSEL_MAX 8'h07
`define PBS_LOCK_UNLOCKED 3'h0
`define PBS_LOCK_MAX 3'h5
`define PBS_DSEL_RESET 8'h00
`define PBS_MARK_RESET 4'h0
`endif

// [core/pbs_pkg.sv]
// types shared by the power budget and status register bank
package pbs_pkg;
   typedef struct packed
   {
      logic [2:0] lock_state;
      logic [3:0] marker;
      logic ccus;
      logic ccds;
      logic [2:0] mode;
   } pbs_status_type;
   typedef struct packed
   {
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
      logic [3:0] be;
   } pbs_req_type;
   typedef enum logic [1:0]
   {
      PBS_IDLE = 2'b00,
      PBS_ACK = 2'b01
   } pbs_bus_state_type;
endpackage

// [core/pbs_regs.sv]
// power budget allocation, budget value table and switch status registers
// Summary of operation
// - allocated flag says power already budgeted
// - eight budget words at 0x300 to 0x31C
// - budget words writable while value unlock set
// - budget words read-only while unlock clear
// - mode field holds mode straps caught at reset
// - downstream clock strap caught at reset
// - upstream clock strap caught at reset
// - lock state field, zero means unlocked
// - marker field rw, survives hot reset
// - value unlock bit is sticky, global
// - allocated flag writable only when unlocked
// - readback picks selected word, else zero
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`include "pbs_params.svh"
module pbs_regs
   import pbs_pkg::*;
#(
   parameter int NUM_WORDS = `PBS_NUM_WORDS
)
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hot_rst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [2:0] mode_pins,
   input wire logic ccds_pin,
   input wire logic ccus_pin,
   input wire logic [2:0] upstream_lock_state,
   output logic system_allocated_flag,
   output logic budget_value_unlock,
   output logic register_write_unlock
);
   logic [31:0] word_q [NUM_WORDS];
   logic [7:0] dsel_q;
   logic sa_q;
   logic regul_q;
   logic bdvul_q;
   logic [3:0] marker_q;
   logic [2:0] lock_q;
   logic [2:0] lock_s1_q;
   logic [2:0] lock_s2_q;
   logic [31:0] rdata_q;
   logic wait_q;
   logic sa_out_q;
   logic bdvul_out_q;
   logic regul_out_q;
   logic hrst_s1_q;
   logic hrst_s2_q;
   logic [2:0] strap_mode;
   logic strap_ccds;
   logic strap_ccus;
   pbs_bus_state_type state_q;
   pbs_req_type req;
   pbs_status_type sts;

   pbs_strap_capture u_strap
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .mode_pins(mode_pins),
      .ccds_pin(ccds_pin),
      .ccus_pin(ccus_pin),
      .mode_q(strap_mode),
      .ccds_q(strap_ccds),
      .ccus_q(strap_ccus)
   );

   assign req.addr = avs_address;
   assign req.rd = avs_read;
   assign req.wr = avs_write;
   assign req.wdata = avs_writedata;
   assign req.be = avs_byteenable;

   // every access is answered in the second cycle: idle takes it, ack ends it
   wire take = (state_q == PBS_IDLE) && (req.rd || req.wr);
   wire wr_go = take && req.wr;
   wire [31:0] bmask = {{8{req.be[3]}}, {8{req.be[2]}},
      {8{req.be[1]}}, {8{req.be[0]}}};
   wire [31:0] wmerge_ctrl = ({27'h0, bdvul_q, regul_q, 3'h0} & ~bmask)
      | (req.wdata & bmask);
   wire hit_dsel = req.addr == `PBS_OFF_DSEL;
   wire hit_bdata = req.addr == `PBS_OFF_BDATA;
   wire hit_alloc = req.addr == `PBS_OFF_ALLOC;
   wire hit_table = (req.addr >= `PBS_OFF_TABLE)
      && (req.addr <= `PBS_OFF_TABLE_LAST)
      && (req.addr[1:0] == 2'b00);
   wire [2:0] table_idx = req.addr[4:2];
   wire hit_status = req.addr == `PBS_OFF_STATUS;
   wire hit_ctrl = req.addr == `PBS_OFF_CTRL;
   wire hit_lock = req.addr == `PBS_OFF_LOCK;
   wire dsel_ok = dsel_q <= `PBS_DSEL_MAX;
   wire [31:0] bdata_val = dsel_ok ? word_q[dsel_q[2:0]] : 32'h0;
   // out-of-range lock codes from the port logic are shown as unlocked
   wire [2:0] lock_clean = (lock_s2_q <= `PBS_LOCK_MAX) ? lock_s2_q
      : `PBS_LOCK_UNLOCKED;

   assign sts.mode = strap_mode;
   assign sts.ccds = strap_ccds;
   assign sts.ccus = strap_ccus;
   assign sts.marker = marker_q;
   assign sts.lock_state = lock_q;
   wire [31:0] status_word = {sts.marker, 5'h00, sts.lock_state, 13'h0000,
      sts.ccus, sts.ccds, 2'b00, sts.mode};

   wire [31:0] rd_mux = hit_dsel ? {24'h0, dsel_q}
      : hit_bdata ? bdata_val
      : hit_alloc ? {31'h0, sa_q}
      : hit_table ? word_q[table_idx]
      : hit_status ? status_word
      : hit_ctrl ? {27'h0, bdvul_q, regul_q, 3'h0}
      : 32'h0;

   // bus handshake; unmapped reads return zero and unmapped writes vanish
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= PBS_IDLE;
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end
      else if (take)
      begin
         state_q <= PBS_ACK;
         wait_q <= 1'b0;
         rdata_q <= req.rd ? rd_mux : rdata_q;
      end
      else
      begin
         state_q <= PBS_IDLE;
         wait_q <= 1'b1;
      end
   end
   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   // hot reset enters as a pin, so it is synchronised first
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hrst_s1_q <= 1'b0;
         hrst_s2_q <= 1'b0;
      end
      else
      begin
         hrst_s1_q <= hot_rst_n;
         hrst_s2_q <= hrst_s1_q;
      end
   end
   wire hot_active = !hrst_s2_q;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lock_s1_q <= `PBS_LOCK_UNLOCKED;
         lock_s2_q <= `PBS_LOCK_UNLOCKED;
         lock_q <= `PBS_LOCK_UNLOCKED;
      end
      else
      begin
         lock_s1_q <= upstream_lock_state;
         lock_s2_q <= lock_s1_q;
         lock_q <= hot_active ? `PBS_LOCK_UNLOCKED : lock_clean;
      end
   end

   // sticky bits: only fundamental reset touches them
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         regul_q <= 1'b0;
         bdvul_q <= 1'b0;
         marker_q <= `PBS_MARK_RESET;
      end
      else if (wr_go && hit_ctrl)
      begin
         regul_q <= wmerge_ctrl[`PBS_CTRL_REGUL_BIT];
         // value unlock is itself guarded by the register unlock
         if (regul_q)
            bdvul_q <= wmerge_ctrl[`PBS_CTRL_BDVUL_BIT];
      end
      else if (wr_go && hit_status && req.be[3])
         marker_q <= req.wdata[31:28];
   end

   // data select and allocated flag are ordinary state, cleared by hot reset
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dsel_q <= `PBS_DSEL_RESET;
         sa_q <= 1'b0;
      end
      else if (hot_active)
      begin
         dsel_q <= `PBS_DSEL_RESET;
         sa_q <= 1'b0;
      end
      else
      begin
         if (wr_go && hit_dsel && req.be[0])
            dsel_q <= req.wdata[7:0];
         if (wr_go && hit_alloc && req.be[0] && regul_q)
            sa_q <= req.wdata[`PBS_ALLOC_SA_BIT];
      end
   end

   // words have no reset at all, so they hold through every reset kind;
   // the eeprom loader writes them over this bus while unlocked
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WORDS; gi++)
      begin : g_word
         wire sel = wr_go && hit_table && (table_idx == 3'(gi));
         for (genvar b = 0; b < 4; b++)
         begin : g_byte
            always_ff @(posedge sys_clk)
            begin
               if (sel && bdvul_q && req.be[b])
                  word_q[gi][8*b +: 8] <= req.wdata[8*b +: 8];
            end
         end
      end
   endgenerate

   // outputs registered so the consumers see clean levels
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sa_out_q <= 1'b0;
         bdvul_out_q <= 1'b0;
         regul_out_q <= 1'b0;
      end
      else
      begin
         sa_out_q <= sa_q;
         bdvul_out_q <= bdvul_q;
         regul_out_q <= regul_q;
      end
   end
   assign system_allocated_flag = sa_out_q;
   assign budget_value_unlock = bdvul_out_q;
   assign register_write_unlock = regul_out_q;
endmodule // pbs_regs

// [core/pbs_strap_capture.sv]
// samples the mode and common-clock straps while fundamental reset is held
`timescale 1ns/1ps
module pbs_strap_capture
   import pbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [2:0] mode_pins,
   input wire logic ccds_pin,
   input wire logic ccus_pin,
   output logic [2:0] mode_q,
   output logic ccds_q,
   output logic ccus_q
);
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic [4:0] held_q;
   // straps cross into sys_clk; the capture keeps tracking while reset is
   // low and freezes once the core leaves reset, so the level seen during
   // fundamental reset stays until the next one
   always_ff @(posedge sys_clk)
   begin
      sync1_q <= {mode_pins, ccds_pin, ccus_pin};
      sync2_q <= sync1_q;
   end
   logic nrst_s1_q;
   logic nrst_s2_q;
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         nrst_s1_q <= 1'b0;
         nrst_s2_q <= 1'b0;
      end
      else
      begin
         nrst_s1_q <= 1'b1;
         nrst_s2_q <= nrst_s1_q;
      end
   end
   // a clocked process without async reset so the pin value may be loaded
   always_ff @(posedge sys_clk)
   begin
      if (!nrst_s2_q)
         held_q <= sync2_q;
   end
   assign mode_q = held_q[4:2];
   assign ccds_q = held_q[1];
   assign ccus_q = held_q[0];
endmodule // pbs_strap_capture

// [dv/pbs_regs_asserts.sv]
// port assertions for the power budget and status bank
`timescale 1ns/1ps
module pbs_regs_asserts
   import pbs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hot_rst_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic system_allocated_flag,
   input wire logic budget_value_unlock,
   input wire logic register_write_unlock
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire ans = !avs_waitrequest;
   wire rd_ans = avs_read && ans;
   // waitrequest is one cycle low per access
   chk_wait_pulse: assert property (ans |=> !ans)
      else $error("waitrequest low twice");
   chk_wait_cause: assert property (
      ans |-> $past(avs_read || avs_write))
      else $error("answer without request");
   chk_req_answer: assert property (
      (avs_read || avs_write) && !ans |-> ##[1:2] ans)
      else $error("request not answered");
   chk_flag_set: assert property (
      $rose(system_allocated_flag) |->
      $past(avs_write) && $past(avs_address) == 12'h28C
      && $past(register_write_unlock))
      else $error("allocated flag set without unlocked write");
   chk_vunl_set: assert property (
      $rose(budget_value_unlock) |->
      $past(avs_write) && $past(avs_address) == 12'h404
      && $past(register_write_unlock))
      else $error("value unlock set without unlocked write");
   chk_unmapped_zero: assert property (
      rd_ans && avs_address == 12'h408 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_sts_fields: assert property (
      rd_ans && avs_address == 12'h400
      |-> avs_readdata[27:23] == 5'h0 && avs_readdata[19:7] == 13'h0
      && avs_readdata[4:3] == 2'h0 && avs_readdata[22:20] <= 3'h5)
      else $error("status reserved bits or lock code wrong");
   chk_alloc_read: assert property (
      rd_ans && avs_address == 12'h28C
      |-> avs_readdata == {31'h0, system_allocated_flag})
      else $error("allocation read disagrees with flag");
   chk_hot_clear: assert property (
      $fell(hot_rst_n) |-> ##[1:4] !system_allocated_flag)
      else $error("hot reset left allocated flag set");
endmodule // pbs_regs_asserts
bind pbs_regs pbs_regs_asserts chk_u (.sys_clk, .nrst, .hot_rst_n,
   .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .system_allocated_flag, .budget_value_unlock, .register_write_unlock);

// [dv/test_pbs_regs.sv]
// self-checking bench for the power budget and status bank
`timescale 1ns/1ps
module test_pbs_regs
   import pbs_pkg::*;
;
   logic sys_clk, nrst, hot_rst_n, avs_read, avs_write, ccds_pin, ccus_pin;
   logic avs_waitrequest, system_allocated_flag;
   logic budget_value_unlock, register_write_unlock;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [2:0] mode_pins, upstream_lock_state;
   logic [31:0] w [8];
   int num_errors, compares;
   pbs_regs dut_u (.sys_clk, .nrst, .hot_rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .mode_pins, .ccds_pin, .ccus_pin,
      .upstream_lock_state, .system_allocated_flag, .budget_value_unlock,
      .register_write_unlock);
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic wrap_up;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] be);
      int n;
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40)
      begin
         num_errors++;
         wrap_up();
      end
      // slave idles a cycle after each answer
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input logic [11:0] a, input string n,
      input logic [31:0] e);
      xfer(1'b0, a, 32'h0, 4'hF);
      chk(n, e, q);
   endtask
   task automatic freset(input logic [2:0] m, input logic ds, us);
      nrst <= 1'b0;
      mode_pins <= m;
      ccds_pin <= ds;
      ccus_pin <= us;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      // straps move after release so a live mirror would be caught
      mode_pins <= ~m;
      ccds_pin <= ~ds;
      ccus_pin <= ~us;
   endtask
   function automatic logic [31:0] sts(logic [3:0] mk, logic [2:0] lk,
      logic us, ds, logic [2:0] m);
      return {mk, 5'h0, lk, 13'h0, us, ds, 2'h0, m};
   endfunction
   initial
   begin
      num_errors = 0;
      compares = 0;
      nrst = 1'b0;
      hot_rst_n = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 12'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      mode_pins = 3'h1;
      ccds_pin = 1'b1;
      ccus_pin = 1'b0;
      upstream_lock_state = 3'h0;
      @(posedge sys_clk);
      freset(3'h1, 1'b1, 1'b0);
      rd(12'h28C, "alloc", 32'h0);
      rd(12'h400, "status", sts(4'h0, 3'h0, 1'b0, 1'b1, 3'h1));
      rd(12'h408, "unmapped", 32'h0);
      $display("reset test done");
      wr(12'h404, 32'h10);
      chk("vunl", 32'h0, {31'h0, budget_value_unlock});
      wr(12'h404, 32'h08);
      wr(12'h404, 32'h18);
      chk("vunl", 32'h1, {31'h0, budget_value_unlock});
      for (int i = 0; i < 8; i++)
      begin
         w[i] = 32'hA5C3_0000 | 32'(i * 273);
         wr(12'(12'h300 + 4 * i), w[i]);
      end
      for (int i = 0; i < 8; i++)
      begin
         rd(12'(12'h300 + 4 * i), "word", w[i]);
         wr(12'h284, 32'(i));
         rd(12'h288, "readback", w[i]);
      end
      wr(12'h284, 32'h8);
      rd(12'h288, "readback", 32'h0);
      xfer(1'b1, 12'h304, 32'h1234_5678, 4'h1);
      w[1][7:0] = 8'h78;
      rd(12'h304, "word", w[1]);
      wr(12'h404, 32'h08);
      wr(12'h31C, 32'hFFFF_FFFF);
      rd(12'h31C, "word", w[7]);
      $display("table test done");
      wr(12'h28C, 32'hFFFF_FFFF);
      rd(12'h28C, "alloc", 32'h1);
      chk("flag", 32'h1, {31'h0, system_allocated_flag});
      wr(12'h404, 32'h0);
      wr(12'h28C, 32'h0);
      rd(12'h28C, "alloc", 32'h1);
      $display("alloc test done");
      wr(12'h400, 32'hFFFF_FFFF);
      for (int k = 0; k < 8; k++)
      begin
         upstream_lock_state <= 3'(k);
         repeat (4) @(posedge sys_clk);
         rd(12'h400, "status", sts(4'hF, (k > 5) ? 3'h0 : 3'(k),
            1'b0, 1'b1, 3'h1));
      end
      upstream_lock_state <= 3'h0;
      $display("status test done");
      wr(12'h404, 32'h08);
      wr(12'h28C, 32'h1);
      hot_rst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      hot_rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(12'h28C, "alloc", 32'h0);
      rd(12'h400, "status", sts(4'hF, 3'h0, 1'b0, 1'b1, 3'h1));
      rd(12'h300, "word", w[0]);
      chk("regunl", 32'h1, {31'h0, register_write_unlock});
      $display("hot reset test done");
      freset(3'h0, 1'b0, 1'b1);
      rd(12'h400, "status", sts(4'h0, 3'h0, 1'b1, 1'b0, 3'h0));
      $display("second reset test done");
      wrap_up();
   end
endmodule // test_pbs_regs
